// ==== hdl/tpgc_cfg.svh ====
// Register map, field positions, reset values and timing counts of the thermal protector block.
`ifndef TPGC_CFG_SVH
`define TPGC_CFG_SVH
// ==========================================================
// Register byte offsets
`define TPGC_THR_OFF 8'h00
`define TPGC_CB_OFF 8'h04
`define TPGC_CTRL_OFF 8'h08
`define TPGC_CONF_OFF 8'h0C
`define TPGC_STAT_OFF 8'h1C
`define TPGC_OT_OFF 8'h20
`define TPGC_UT_OFF 8'h24
`define TPGC_SYS_OFF 8'h28
`define TPGC_PIN_OFF 8'h2C
`define TPGC_MISC_OFF 8'h30
`define TPGC_CUR_OFF 8'h34
`define TPGC_PAUSE_OFF 8'h38
// ==========================================================
// Field positions
`define TPGC_CTRL_LOCK_LSB 2
`define TPGC_CTRL_GO_BIT 5
`define TPGC_CONF_SPI_BIT 6
`define TPGC_CONF_FIN_BIT 7
`define TPGC_CONF_CSR_BIT 6
`define TPGC_MISC_THERMISTOR_REFERENCE_SUPPLY_BIT 0
`define TPGC_MISC_ALERT_BIT 1
`define TPGC_MISC_MB_LSB 8
// ==========================================================
// Reset values and timing
`define TPGC_RST_BYTE 8'h00
`define TPGC_SLOT_CYCLES 8
`endif

// ==== hdl/tpgc_pkg.sv ====
// Types shared by the thermal protector and pin configuration block.
package tpgc_pkg;
	typedef enum logic [1:0] {
		TPGC_IDLE = 2'b00,
		TPGC_RUN = 2'b01,
		TPGC_TEST = 2'b11,
		TPGC_LOCK = 2'b10
	} tpgc_state_t;
	typedef enum logic [1:0] {
		TPGC_M_STOP = 2'b00,
		TPGC_M_RR = 2'b01,
		TPGC_M_TEST = 2'b10,
		TPGC_M_LOCK = 2'b11
	} tpgc_mode_t;
	typedef enum logic [2:0] {
		TPGC_P_HIZ = 3'h0,
		TPGC_P_DIN = 3'h1,
		TPGC_P_ADC_PROT = 3'h2,
		TPGC_P_ADC = 3'h3,
		TPGC_P_OUT_HI = 3'h4,
		TPGC_P_OUT_LO = 3'h5,
		TPGC_P_ADC_PU = 3'h6,
		TPGC_P_ADC_PD = 3'h7
	} tpgc_pin_cfg_t;
endpackage

// ==== hdl/tpgc_top.sv ====
// Temperature protector control, pin configuration multiplexer and APB register file.
`timescale 1ns/100ps
`include "tpgc_cfg.svh"
module tpgc_top import tpgc_pkg::*; #(
	parameter int SLOT_CYCLES = `TPGC_SLOT_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_q,
	output logic pready_q,
	output logic pslverr_q,
	input wire logic [7:0] pin_ratio,
	input wire logic shutdown,
	input wire logic [7:0] pin_in,
	input wire logic spi_ss,
	input wire logic spi_mosi,
	input wire logic spi_sclk,
	input wire logic cs_conv_done,
	input wire logic [7:0] cs_result_hi,
	output logic [2:0] scan_ch_q,
	output logic meas_block_q,
	output logic running_q,
	output logic [7:0] bal_pause_q,
	output logic [7:0] pin_out_q,
	output logic [7:0] pin_oe_n_q,
	output logic [7:0] pin_pu_q,
	output logic [7:0] pin_pd_q,
	output logic [7:0] pin_adc_q,
	output logic spi_miso_q,
	output logic fault_alert_n_q
);
	// ==========================================================
	// APB slave
	logic done, wr, rd;
	logic [31:0] rd_d;
	logic hit_d;
	assign done = psel & penable & pready_q;
	assign wr = done & pwrite;
	assign rd = done & ~pwrite;

	// Settings as software sees them.
	logic [7:0] thr_q, cb_q, misc_mb_q;
	logic [1:0] mode_q;
	logic [2:0] lock_q;
	logic [7:0][2:0] pin_cfg_q;
	logic spi_en_q, fault_in_en_q, cs_rdy_en_q, thermistor_reference_supply_en_q, alert_en_q;
	// Status.
	logic [7:0] ot_q, ut_q, pin_stat_q;
	logic sys_fault_q, cs_ready_q, abn_q;
	tpgc_state_t st_q;

	function automatic logic is_addr(input logic [7:0] a, input logic [7:0] off);
		is_addr = (a == off);
	endfunction

	always_comb begin
		rd_d = 32'h0000_0000;
		hit_d = 1'b1;
		case (paddr)
			`TPGC_THR_OFF: rd_d[7:0] = thr_q;
			`TPGC_CB_OFF: rd_d[7:0] = cb_q;
			`TPGC_CTRL_OFF: rd_d[4:0] = {lock_q, mode_q};
			`TPGC_STAT_OFF: rd_d[2:0] = {abn_q, st_q == TPGC_TEST, running_q};
			`TPGC_OT_OFF: rd_d[7:0] = ot_q;
			`TPGC_UT_OFF: rd_d[7:0] = ut_q;
			`TPGC_SYS_OFF: rd_d[0] = sys_fault_q;
			`TPGC_PIN_OFF: rd_d[7:0] = pin_stat_q;
			`TPGC_MISC_OFF: rd_d[15:0] = {misc_mb_q, 6'h00, alert_en_q, thermistor_reference_supply_en_q};
			`TPGC_CUR_OFF: rd_d[7:0] = cs_result_hi;
			`TPGC_PAUSE_OFF: rd_d[7:0] = bal_pause_q;
			default: begin
				hit_d = 1'b0;
				for (int n = 0; n < 4; n++) begin
					if (is_addr(paddr, 8'(`TPGC_CONF_OFF + 4 * n))) begin
						hit_d = 1'b1;
						rd_d[5:0] = {pin_cfg_q[2 * n + 1], pin_cfg_q[2 * n]};
						if (n == 0) begin
							rd_d[`TPGC_CONF_SPI_BIT] = spi_en_q;
							rd_d[`TPGC_CONF_FIN_BIT] = fault_in_en_q;
						end
						if (n == 1) begin
							rd_d[`TPGC_CONF_CSR_BIT] = cs_rdy_en_q;
						end
					end
				end
			end
		endcase
	end

	// The answer takes one wait state so read data always comes from a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= psel & penable & ~pready_q;
			if (psel & penable & ~pready_q) begin
				prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
				pslverr_q <= ~hit_d;
			end
		end
	end

	// ==========================================================
	// Configuration registers
	logic go_wr;
	assign go_wr = wr & is_addr(paddr, `TPGC_CTRL_OFF) & pwdata[`TPGC_CTRL_GO_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr_q <= `TPGC_RST_BYTE;
			cb_q <= `TPGC_RST_BYTE;
			mode_q <= 2'h0;
			lock_q <= 3'h0;
			misc_mb_q <= `TPGC_RST_BYTE;
			thermistor_reference_supply_en_q <= 1'b0;
			alert_en_q <= 1'b0;
		end else if (wr) begin
			if (is_addr(paddr, `TPGC_THR_OFF)) begin
				thr_q <= pwdata[7:0];
			end
			if (is_addr(paddr, `TPGC_CB_OFF)) begin
				cb_q <= pwdata[7:0];
			end
			if (is_addr(paddr, `TPGC_CTRL_OFF)) begin
				mode_q <= pwdata[1:0];
				lock_q <= pwdata[`TPGC_CTRL_LOCK_LSB +: 3];
			end
			if (is_addr(paddr, `TPGC_MISC_OFF)) begin
				thermistor_reference_supply_en_q <= pwdata[`TPGC_MISC_THERMISTOR_REFERENCE_SUPPLY_BIT];
				alert_en_q <= pwdata[`TPGC_MISC_ALERT_BIT];
				misc_mb_q <= pwdata[`TPGC_MISC_MB_LSB +: 8];
			end
		end
	end

	// Unprogrammed configuration memory leaves every pin high impedance.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_cfg_q <= '{default: TPGC_P_HIZ};
			spi_en_q <= 1'b0;
			fault_in_en_q <= 1'b0;
			cs_rdy_en_q <= 1'b0;
		end else if (wr) begin
			for (int n = 0; n < 4; n++) begin
				if (is_addr(paddr, 8'(`TPGC_CONF_OFF + 4 * n))) begin
					pin_cfg_q[2 * n] <= pwdata[2:0];
					pin_cfg_q[2 * n + 1] <= pwdata[5:3];
					if (n == 0) begin
						spi_en_q <= pwdata[`TPGC_CONF_SPI_BIT];
						fault_in_en_q <= pwdata[`TPGC_CONF_FIN_BIT];
					end
					if (n == 1) begin
						cs_rdy_en_q <= pwdata[`TPGC_CONF_CSR_BIT];
					end
				end
			end
		end
	end

	// ==========================================================
	// Protector sequencer
	logic [4:0] ot_c_q, cb_c_q;
	logic [2:0] ut_c_q, hyst_c_q, lock_c_q;
	logic [7:0] act_c_q;
	logic [3:0] slot_q;
	logic eval, abn_go;
	assign eval = (st_q == TPGC_RUN || st_q == TPGC_LOCK) && slot_q == 4'(SLOT_CYCLES - 1);
	assign abn_go = go_wr & ~thermistor_reference_supply_en_q & (pwdata[1:0] != TPGC_M_STOP);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ot_c_q <= 5'h00;
			ut_c_q <= 3'h0;
			cb_c_q <= 5'h00;
			hyst_c_q <= 3'h0;
			lock_c_q <= 3'h0;
			act_c_q <= 8'h00;
		end else if (go_wr) begin
			ot_c_q <= thr_q[4:0];
			ut_c_q <= thr_q[7:5];
			cb_c_q <= cb_q[4:0];
			hyst_c_q <= cb_q[7:5];
			lock_c_q <= pwdata[`TPGC_CTRL_LOCK_LSB +: 3];
			for (int i = 0; i < 8; i++) begin
				act_c_q[i] <= pin_cfg_q[i] == TPGC_P_ADC_PROT;
			end
		end
	end

	// Sleep is not an input here: only a stop command or shutdown ends a run.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= TPGC_IDLE;
			slot_q <= 4'h0;
			scan_ch_q <= 3'h0;
			abn_q <= 1'b0;
		end else if (shutdown) begin
			st_q <= TPGC_IDLE;
			slot_q <= 4'h0;
		end else if (go_wr) begin
			slot_q <= 4'h0;
			abn_q <= abn_go;
			scan_ch_q <= 3'h0;
			case (pwdata[1:0])
				TPGC_M_RR: st_q <= TPGC_RUN;
				TPGC_M_TEST: st_q <= TPGC_TEST;
				TPGC_M_LOCK: begin
					st_q <= TPGC_LOCK;
					scan_ch_q <= pwdata[`TPGC_CTRL_LOCK_LSB +: 3];
				end
				default: st_q <= TPGC_IDLE;
			endcase
		end else if (st_q != TPGC_IDLE) begin
			slot_q <= (slot_q == 4'(SLOT_CYCLES - 1)) ? 4'h0 : slot_q + 4'h1;
			if (eval && st_q == TPGC_RUN) begin
				scan_ch_q <= scan_ch_q + 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running_q <= 1'b0;
			meas_block_q <= 1'b0;
		end else begin
			running_q <= (st_q != TPGC_IDLE);
			meas_block_q <= (st_q == TPGC_TEST);
		end
	end

	// ==========================================================
	// Detection and sticky fault flags
	logic [7:0] ch_oh, ot_set, ut_set, ot_clr, ut_clr;
	logic ch_act;
	assign ch_oh = 8'h01 << scan_ch_q;
	assign ch_act = eval & act_c_q[scan_ch_q];
	// The same captured thresholds are compared for whichever pin is scanned.
	assign ot_set = ((ch_act && pin_ratio[7:3] < ot_c_q) ? ch_oh : 8'h00) | {8{abn_go}};
	assign ut_set = ((ch_act && pin_ratio[7:5] > ut_c_q) ? ch_oh : 8'h00) | {8{abn_go}};
	assign ot_clr = (wr && is_addr(paddr, `TPGC_OT_OFF)) ? pwdata[7:0] : 8'h00;
	assign ut_clr = (wr && is_addr(paddr, `TPGC_UT_OFF)) ? pwdata[7:0] : 8'h00;

	// Write one to clear; a detection in the same cycle wins.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ot_q <= 8'h00;
			ut_q <= 8'h00;
		end else begin
			ot_q <= (ot_q & ~ot_clr) | ot_set;
			ut_q <= (ut_q & ~ut_clr) | ut_set;
		end
	end

	// Pause releases only once the ratio reaches threshold plus hysteresis.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bal_pause_q <= 8'h00;
		end else if (ch_act && st_q == TPGC_RUN) begin
			if (pin_ratio[7:3] < cb_c_q) begin
				bal_pause_q <= bal_pause_q | ch_oh;
			end else if ({1'b0, pin_ratio[7:3]} >= 6'({1'b0, cb_c_q} + {3'h0, hyst_c_q})) begin
				bal_pause_q <= bal_pause_q & ~ch_oh;
			end
		end
	end

	// ==========================================================
	// Special pin functions
	logic sys_clr;
	assign sys_clr = wr & is_addr(paddr, `TPGC_SYS_OFF) & pwdata[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_fault_q <= 1'b0;
			fault_alert_n_q <= 1'b1;
			cs_ready_q <= 1'b0;
		end else begin
			sys_fault_q <= (sys_fault_q & ~sys_clr) | (fault_in_en_q & ~pin_in[7]);
			fault_alert_n_q <= ~(alert_en_q & sys_fault_q);
			if (cs_conv_done & cs_rdy_en_q) begin
				cs_ready_q <= 1'b1;
			end else if (rd && is_addr(paddr, `TPGC_CUR_OFF)) begin
				cs_ready_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Pin multiplexer
	logic [7:0] out_d, oe_n_d, pu_d, pd_d, adc_d, stat_d;

	always_comb begin
		out_d = 8'h00;
		oe_n_d = 8'hFF;
		pu_d = 8'h00;
		pd_d = 8'h00;
		adc_d = 8'h00;
		stat_d = 8'h00;
		for (int i = 0; i < 8; i++) begin
			case (pin_cfg_q[i])
				TPGC_P_DIN: stat_d[i] = pin_in[i];
				TPGC_P_ADC_PROT, TPGC_P_ADC: adc_d[i] = 1'b1;
				TPGC_P_OUT_HI: begin
					out_d[i] = 1'b1;
					oe_n_d[i] = 1'b0;
				end
				TPGC_P_OUT_LO: oe_n_d[i] = 1'b0;
				TPGC_P_ADC_PU: begin
					adc_d[i] = 1'b1;
					pu_d[i] = 1'b1;
				end
				TPGC_P_ADC_PD: begin
					adc_d[i] = 1'b1;
					pd_d[i] = 1'b1;
				end
				default: ;
			endcase
		end
		if (cs_rdy_en_q) begin
			out_d[0] = ~cs_ready_q;
			oe_n_d[0] = 1'b0;
		end
		if (misc_mb_q != 8'h00) begin
			out_d[2] = 1'b1;
			oe_n_d[2] = 1'b0;
		end
		if (spi_en_q) begin
			out_d[6:3] = {spi_sclk, spi_mosi, 1'b0, spi_ss};
			oe_n_d[6:3] = 4'b0010;
			{pu_d[6:3], pd_d[6:3], adc_d[6:3]} = 12'h000;
		end
		if (fault_in_en_q) begin
			out_d[7] = 1'b0;
			oe_n_d[7] = 1'b1;
			{pu_d[7], pd_d[7], adc_d[7]} = 3'h0;
		end
		if (st_q == TPGC_TEST) begin
			adc_d = 8'h00;
		end
		for (int i = 0; i < 8; i++) begin
			if (!oe_n_d[i]) begin
				stat_d[i] = out_d[i];
			end
		end
		if (shutdown) begin
			oe_n_d = 8'hFF;
			pu_d = 8'h00;
			pd_d = 8'hFF;
			adc_d = 8'h00;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out_q <= 8'h00;
			pin_oe_n_q <= 8'hFF;
			pin_pu_q <= 8'h00;
			pin_pd_q <= 8'h00;
			pin_adc_q <= 8'h00;
			pin_stat_q <= 8'h00;
			spi_miso_q <= 1'b0;
		end else begin
			pin_out_q <= out_d;
			pin_oe_n_q <= oe_n_d;
			pin_pu_q <= pu_d;
			pin_pd_q <= pd_d;
			pin_adc_q <= adc_d;
			pin_stat_q <= stat_d;
			spi_miso_q <= spi_en_q & pin_in[4];
		end
	end

	// ==========================================================
	// Checks
	sequence cs_done_s;
		cs_conv_done && cs_rdy_en_q && !shutdown;
	endsequence
	sequence pin_low_s;
		##2 !pin_out_q[0];
	endsequence
	sequence slot_gap_s;
		!eval [*7];
	endsequence

	chk_thr_capture: assert property (@(posedge pclk) disable iff (!presetn)
		go_wr |=> ot_c_q == $past(thr_q[4:0]) && ut_c_q == $past(thr_q[7:5]))
		else $error("thresholds not captured on go");
	chk_ot_detect: assert property (@(posedge pclk) disable iff (!presetn)
		ch_act && pin_ratio[7:3] < ot_c_q |=> ot_q[$past(scan_ch_q)])
		else $error("over-temperature not flagged");
	chk_ut_detect: assert property (@(posedge pclk) disable iff (!presetn)
		ch_act && pin_ratio[7:5] > ut_c_q |=> ut_q[$past(scan_ch_q)])
		else $error("under-temperature not flagged");
	chk_inactive_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		eval && !act_c_q[scan_ch_q] && !go_wr |=> ot_q == ($past(ot_q) & ~$past(ot_clr)))
		else $error("inactive pin changed a fault flag");
	chk_no_thermistor_reference_supply: assert property (@(posedge pclk) disable iff (!presetn)
		abn_go |=> ot_q == 8'hFF && ut_q == 8'hFF)
		else $error("missing reference did not flag all faults");
	chk_rr_slot: assert property (@(posedge pclk) disable iff (!presetn || go_wr || shutdown)
		eval && st_q == TPGC_RUN && !go_wr && !shutdown |=> slot_gap_s ##1 eval)
		else $error("round robin slot timing wrong");
	chk_lock_channel: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == TPGC_LOCK |-> scan_ch_q == lock_c_q)
		else $error("single channel not locked");
	chk_test_quiet: assert property (@(posedge pclk) disable iff (!presetn)
		st_q == TPGC_TEST && !go_wr |-> (ot_set | ut_set) == 8'h00 ##1 meas_block_q)
		else $error("detection during self-test");
	chk_sticky_flags: assert property (@(posedge pclk) disable iff (!presetn)
		ot_clr == 8'h00 |=> (ot_q & $past(ot_q)) == $past(ot_q))
		else $error("fault flag dropped without clear");
	chk_cs_ready: assert property (@(posedge pclk) disable iff (!presetn)
		cs_done_s |-> pin_low_s)
		else $error("current ready pin not low");
	chk_spi_mux: assert property (@(posedge pclk) disable iff (!presetn)
		spi_en_q && !shutdown |=> pin_out_q[5] == $past(spi_mosi) && !pin_oe_n_q[5])
		else $error("spi takeover missing");
	chk_shutdown_pd: assert property (@(posedge pclk) disable iff (!presetn)
		shutdown |=> pin_pd_q == 8'hFF && pin_oe_n_q == 8'hFF)
		else $error("shutdown pull-down missing");
endmodule

// ==== dv/tpgc_ntc_model.sv ====
// Behavioural thermistor networks that present a ratio for the pin being scanned.
`timescale 1ns/100ps
module tpgc_ntc_model (
	input wire logic [2:0] scan_ch,
	input wire logic [63:0] ratios,
	output logic [7:0] pin_ratio
);
	// ==========================================================
	// Ratio selection
	// Each network is a fixed divider, so its ratio follows only the channel being compared.
	assign pin_ratio = ratios[scan_ch * 8 +: 8];
endmodule

// ==== dv/tb_top.sv ====
// Self-checking testbench for the thermal protector and pin configuration block.
`timescale 1ns/100ps
module tb_top;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic shutdown = 1'b0;
	logic spi_ss = 1'b0;
	logic spi_mosi = 1'b0;
	logic spi_sclk = 1'b0;
	logic cs_conv_done = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [7:0] pin_in = 8'h00;
	logic [7:0] cs_result_hi = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [63:0] ratios = {8{8'h88}};
	logic [31:0] prdata_q, rd_q;
	logic pready_q, pslverr_q, err_q, meas_block_q, running_q, spi_miso_q, fault_alert_n_q;
	logic [2:0] scan_ch_q;
	logic [7:0] pin_ratio, bal_pause_q, pin_out_q, pin_oe_n_q, pin_pu_q, pin_pd_q, pin_adc_q;
	logic [4:0] mux_exp [8] = '{5'h10, 5'h10, 5'h11, 5'h11, 5'h08, 5'h00, 5'h15, 5'h13};
	int fails = 0;
	int check_count = 0;
	int cyc = 0;

	always #25 pclk = ~pclk;

	tpgc_top #(.SLOT_CYCLES(8)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q), .pready_q(pready_q),
		.pslverr_q(pslverr_q), .pin_ratio(pin_ratio), .shutdown(shutdown), .pin_in(pin_in),
		.spi_ss(spi_ss), .spi_mosi(spi_mosi), .spi_sclk(spi_sclk), .cs_conv_done(cs_conv_done),
		.cs_result_hi(cs_result_hi), .scan_ch_q(scan_ch_q), .meas_block_q(meas_block_q),
		.running_q(running_q), .bal_pause_q(bal_pause_q), .pin_out_q(pin_out_q), .pin_oe_n_q(pin_oe_n_q),
		.pin_pu_q(pin_pu_q), .pin_pd_q(pin_pd_q), .pin_adc_q(pin_adc_q), .spi_miso_q(spi_miso_q),
		.fault_alert_n_q(fault_alert_n_q));

	tpgc_ntc_model u_ntc (.scan_ch(scan_ch_q), .ratios(ratios), .pin_ratio(pin_ratio));

	// ==========================================================
	// Shared tasks
	task wrap_up;
		$display("checks=%0d fails=%0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; the request holds until pready is seen high.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready_q !== 1'b1);
		rd_q = prdata_q;
		err_q = pslverr_q;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			fails++;
			wrap_up;
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		ratios[7:0] <= 8'h20;
		ratios[15:8] <= 8'h20;
		ratios[23:16] <= 8'hE0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(pin_oe_n_q, 32'hFF);
		rd(8'h0C);
		chk(rd_q, 32'h0);
		rd(8'h3C);
		chk(rd_q, 32'h0);
		chk(err_q, 32'h1);
		wr(8'h00, 32'hB0);
		wr(8'h04, 32'h05);
		wr(8'h0C, 32'h1A);
		wr(8'h10, 32'h02);
		wr(8'h30, 32'h01);
		wr(8'h08, 32'h21);
		repeat (80) @(posedge pclk);
		rd(8'h20);
		chk(rd_q, 32'h01);
		rd(8'h24);
		chk(rd_q, 32'h04);
		rd(8'h38);
		chk(rd_q, 32'h01);
		chk(bal_pause_q, 32'h01);
		rd(8'h1C);
		chk(rd_q, 32'h01);
		// Late threshold change must not act before the next go.
		ratios[7:0] <= 8'h88;
		wr(8'h00, 32'hBF);
		repeat (80) @(posedge pclk);
		rd(8'h20);
		chk(rd_q, 32'h01);
		wr(8'h20, 32'hFF);
		rd(8'h20);
		chk(rd_q, 32'h0);
		wr(8'h08, 32'h21);
		repeat (80) @(posedge pclk);
		rd(8'h20);
		chk(rd_q, 32'h05);
		wr(8'h30, 32'h00);
		wr(8'h08, 32'h21);
		repeat (20) @(posedge pclk);
		rd(8'h20);
		chk(rd_q, 32'hFF);
		rd(8'h24);
		chk(rd_q, 32'hFF);
		wr(8'h30, 32'h01);
		// Clear only after self-test has begun, so a flag seen later can only come from self-test.
		wr(8'h08, 32'h22);
		wr(8'h20, 32'hFF);
		repeat (80) @(posedge pclk);
		chk(meas_block_q, 32'h1);
		rd(8'h20);
		chk(rd_q, 32'h0);
		rd(8'h1C);
		chk(rd_q[1:0], 32'h3);
		wr(8'h08, 32'h2B);
		repeat (20) @(posedge pclk);
		chk({meas_block_q, scan_ch_q}, 32'h2);
		wr(8'h08, 32'h20);
		repeat (4) @(posedge pclk);
		chk(running_q, 32'h0);
		pin_in <= 8'h08;
		for (int c = 0; c < 8; c++) begin
			wr(8'h10, 32'h02 | (c << 3));
			repeat (2) @(posedge pclk);
			chk({pin_oe_n_q[3], pin_out_q[3], pin_pu_q[3], pin_pd_q[3], pin_adc_q[3]}, mux_exp[c]);
			rd(8'h2C);
			if (c == 1 || c == 4 || c == 5) begin
				chk(rd_q[3], (c == 5) ? 32'h0 : 32'h1);
			end
		end
		spi_ss <= 1'b1;
		spi_sclk <= 1'b1;
		pin_in <= 8'h10;
		wr(8'h0C, 32'h5A);
		repeat (2) @(posedge pclk);
		chk({spi_miso_q, pin_oe_n_q[6:3], pin_out_q[6], pin_out_q[5], pin_out_q[3]}, 32'h95);
		pin_in <= 8'h00;
		wr(8'h0C, 32'h9A);
		wr(8'h30, 32'h03);
		repeat (3) @(posedge pclk);
		rd(8'h28);
		chk(rd_q, 32'h1);
		chk(fault_alert_n_q, 32'h0);
		pin_in <= 8'h80;
		wr(8'h28, 32'h01);
		rd(8'h28);
		repeat (2) @(posedge pclk);
		chk(rd_q, 32'h0);
		chk(fault_alert_n_q, 32'h1);
		wr(8'h10, 32'h40);
		cs_result_hi <= 8'h5C;
		cs_conv_done <= 1'b1;
		@(posedge pclk);
		cs_conv_done <= 1'b0;
		repeat (3) @(posedge pclk);
		chk({pin_oe_n_q[0], pin_out_q[0]}, 32'h0);
		rd(8'h34);
		repeat (2) @(posedge pclk);
		chk({rd_q[7:0], pin_out_q[0]}, 32'hB9);
		wr(8'h30, 32'h0503);
		repeat (2) @(posedge pclk);
		chk({pin_oe_n_q[2], pin_out_q[2]}, 32'h1);
		shutdown <= 1'b1;
		repeat (3) @(posedge pclk);
		chk({pin_pd_q, pin_pu_q, pin_oe_n_q}, 32'hFF00FF);
		wrap_up;
	end
endmodule
